// File: pwr_pkg.sv
/*
  Shared constants for the regulator enable, clock and load monitor.
  Assumes a 125 MHz system clock and byte addresses on an APB bus.
*/
package pwr_pkg;

  localparam int CLK_PERIOD_NS    = 8;
  localparam int MEAS_TIME_NS     = 50000;
  localparam int MEAS_CYCLES_DFLT = MEAS_TIME_NS / CLK_PERIOD_NS;
  localparam int DELAY_STEP_NS    = 1000000;
  localparam int DELAY_STEP_DFLT  = DELAY_STEP_NS / CLK_PERIOD_NS;
  localparam int DET_WINDOW_NS    = 10000;
  localparam int DET_WINDOW_CYC   = DET_WINDOW_NS / CLK_PERIOD_NS;
  localparam int DET_EDGES_PER_MHZ = DET_WINDOW_NS / 1000;
  localparam int DET_LO_PCT       = 70;
  localparam int DET_HI_PCT       = 110;

  localparam int         LOAD_LSB_MA   = 20;
  localparam int         PWM_ENTRY_MA  = 600;
  localparam logic [8:0] PWM_CODE      = 9'(PWM_ENTRY_MA / LOAD_LSB_MA);
  localparam logic [4:0] MAX_FREQ_CODE = 5'h17;

  localparam logic [7:0] OFS_CTRL_BASE  = 8'h00;
  localparam logic [7:0] OFS_DELAY_BASE = 8'h10;
  localparam logic [7:0] OFS_CONFIG     = 8'h20;
  localparam logic [7:0] OFS_PLL_CTRL   = 8'h24;
  localparam logic [7:0] OFS_MEAS_SEL   = 8'h28;
  localparam logic [7:0] OFS_LOAD_LOW   = 8'h2C;
  localparam logic [7:0] OFS_LOAD_HIGH  = 8'h30;
  localparam logic [7:0] OFS_FLAGS      = 8'h34;
  localparam logic [7:0] OFS_MASK       = 8'h38;
  localparam logic [7:0] OFS_STATUS     = 8'h3C;
  localparam logic [7:0] OFS_TUNE0      = 8'h40;
  localparam logic [7:0] OFS_TUNE1      = 8'h44;

  localparam int ON_BIT      = 0;
  localparam int PIN_BIT     = 1;
  localparam int FPWM_BIT    = 2;
  localparam int PLL_EN_BIT  = 0;
  localparam int FREQ_LSB    = 8;
  localparam int FLAG_MEAS   = 0;
  localparam int FLAG_SYNC   = 1;
  localparam int DLY_ON_LSB  = 0;
  localparam int DLY_OFF_LSB = 4;

  typedef enum logic [1:0] {ST_OTP_LOAD, ST_STANDBY, ST_ACTIVE} pwr_state_e;

endpackage

// File: reg_enable_delay.sv
/*
  Enable path of one regulator: register control or delayed pin control.
  Assumes a synchronous pin level, its edge pulses and a delay-step tick.
*/
`timescale 1ns/100ps
module reg_enable_delay (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       allowed,
  input  wire logic       on_bit,
  input  wire logic       pin_follow,
  input  wire logic       pin_level,
  input  wire logic       pin_rise,
  input  wire logic       pin_fall,
  input  wire logic       tick,
  input  wire logic [3:0] dly_on,
  input  wire logic [3:0] dly_off,
  output logic            reg_on
);

  typedef struct packed {
    logic       on;
    logic       armed;
    logic       pend;
    logic       tgt;
    logic [3:0] cnt;
  } ena_s;

  ena_s q;
  ena_s n;

  always_comb begin
    n = q;
    if (!allowed || !on_bit) begin
      n.on   = 1'b0;
      n.pend = 1'b0;
    end else if (!pin_follow) begin
      n.on   = 1'b1;
      n.pend = 1'b0;
    end else if (!q.armed) begin
      n.on   = pin_level;
      n.pend = 1'b0;
    end else if (pin_rise) begin
      n.on   = (dly_on == 4'h0) ? 1'b1 : q.on;
      n.pend = (dly_on != 4'h0);
      n.tgt  = 1'b1;
      n.cnt  = dly_on;
    end else if (pin_fall) begin
      n.on   = (dly_off == 4'h0) ? 1'b0 : q.on;
      n.pend = (dly_off != 4'h0);
      n.tgt  = 1'b0;
      n.cnt  = dly_off;
    end else if (q.pend && tick) begin
      if (q.cnt == 4'h1) begin
        n.on   = q.tgt;
        n.pend = 1'b0;
      end else begin
        n.cnt = q.cnt - 4'h1;
      end
    end
    n.armed = allowed && on_bit && pin_follow;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign reg_on = q.on;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_off_when_clear: assert property (!on_bit |=> !reg_on)
    else $error("regulator on while its enable bit is clear");
  a_reg_mode_direct: assert property (
    allowed && on_bit && !pin_follow |=> reg_on)
    else $error("register-controlled regulator did not turn on");
  a_zero_delay_on: assert property (
    allowed && on_bit && pin_follow && q.armed && pin_rise &&
    dly_on == 4'h0 |=> reg_on)
    else $error("zero turn-on delay did not act at once");

endmodule

// File: pwr_ctrl_top.sv
/*
  Register file, mode selection, load measurement, clock detector and
  regulator enable control of a dual converter, dual linear regulator device.
  Assumes an APB master, synchronous pins and OTP defaults held stable.
*/
// The address map and register access over APB are this design's own decisions.
// Overview of operation
// - Converter runs PWM at 600 mA or more, else PFM unless forced.
// - Forced PWM keeps fixed switching frequency at every load.
// - OTP defaults load at start-up; registers may overwrite them later.
// - Any write to measurement select starts a new load measurement.
// - Measured core is forced to PWM; sequence finishes within 50 us.
// - Measurement completion sets a flag; a mask keeps it off the irq.
// - Result is 9 bits, 20 mA each, split over two readable registers.
// - Dithering applies to both cores only when enabled and PLL is off.
// - PLL off: detector idle, RC clock used, no external-clock interrupt.
// - PLL on: detect clock, use it when valid, flag its changes.
// - A mask bit keeps the sync-clock flag off the interrupt output.
// - Five-bit field selects nominal external clock, 1 to 24 MHz.
// - External clock is valid only within -30 to +10 percent.
// - PLL on: flag missing clock at OTP-to-standby and at first buck enable from standby.
// - After OTP load the device enters standby and accepts control.
// - Regulators may turn on only in standby or active state.
// - Converter follows its bit, or the pin when pin-follow is set.
// - Linear regulators select their enable source like converters.
// - Pin edges turn regulators on or off after programmed delays.
// - Delays apply only to pin edges, never to register writes.
// - Clear enable bit disables a regulator whatever the pin does.
`timescale 1ns/100ps
module pwr_ctrl_top
  import pwr_pkg::*;
#(
  parameter int MEAS_CYCLES       = MEAS_CYCLES_DFLT,
  parameter int DELAY_STEP_CYCLES = DELAY_STEP_DFLT
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        en_pin,
  input  wire logic        sync_clock_input,
  input  wire logic [8:0]  load_sense0,
  input  wire logic [8:0]  load_sense1,
  input  wire logic [1:0]  otp_fpwm,
  input  wire logic [31:0] otp_delays,
  input  wire logic [13:0] otp_tune0,
  input  wire logic [13:0] otp_tune1,
  input  wire logic        otp_pll_en,
  output logic [1:0]       conv_on,
  output logic [1:0]       linear_on,
  output logic [1:0]       conv_pwm,
  output logic             dither_on,
  output logic             detector_on,
  output logic             ext_clock_selected,
  output logic [13:0]      conv_tuning0,
  output logic [13:0]      conv_tuning1,
  output logic             int_out
);

  typedef struct packed {
    pwr_state_e      st;
    logic [1:0]      c_on;
    logic [1:0]      c_pin;
    logic [1:0]      c_fpwm;
    logic [1:0]      l_on;
    logic [1:0]      l_pin;
    logic [3:0][7:0] dly;
    logic [1:0][13:0] tune;
    logic            dith;
    logic            pll_en;
    logic [4:0]      freq;
    logic            sel;
    logic            meas_busy;
    logic [15:0]     meas_cnt;
    logic [8:0]      result;
    logic [1:0]      flags;
    logic [1:0]      mask;
    logic            pin_prev;
    logic            clk_prev;
    logic [10:0]     win_cnt;
    logic [9:0]      edges;
    logic            clk_valid;
    logic [19:0]     tick_cnt;
    logic            tick;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic [1:0]      pwm;
    logic            dither_out;
    logic            det_on;
    logic            ext_sel;
    logic            irq;
  } top_s;

  top_s       q;
  top_s       n;
  logic [3:0] reg_on;
  logic [3:0] on_bits;
  logic [3:0] pin_bits;
  logic       pin_rise;
  logic       pin_fall;
  logic       allowed;

  function automatic logic window_ok(logic [9:0] e, logic [4:0] f);
    int m;
    int lo;
    int hi;
    m  = (f > MAX_FREQ_CODE) ? 24 : int'(f) + 1;
    lo = m * DET_EDGES_PER_MHZ * DET_LO_PCT / 100;
    hi = m * DET_EDGES_PER_MHZ * DET_HI_PCT / 100;
    return (int'(e) >= lo) && (int'(e) <= hi);
  endfunction

  function automatic logic [31:0] read_word(top_s s, logic [7:0] a,
                                            logic [3:0] on);
    logic [31:0] d;
    d = 32'h0;
    if (a[7:4] == OFS_CTRL_BASE[7:4]) begin
      if (a[3] == 1'b0) begin
        d[ON_BIT]   = s.c_on[a[2]];
        d[PIN_BIT]  = s.c_pin[a[2]];
        d[FPWM_BIT] = s.c_fpwm[a[2]];
      end else begin
        d[ON_BIT]  = s.l_on[a[2]];
        d[PIN_BIT] = s.l_pin[a[2]];
      end
    end else if (a[7:4] == OFS_DELAY_BASE[7:4]) begin
      d[7:0] = s.dly[a[3:2]];
    end else begin
      case (a)
        OFS_CONFIG:    d[0] = s.dith;
        OFS_PLL_CTRL: begin
          d[PLL_EN_BIT]            = s.pll_en;
          d[FREQ_LSB+4:FREQ_LSB]   = s.freq;
        end
        OFS_MEAS_SEL:  d[0] = s.sel;
        OFS_LOAD_LOW:  d[7:0] = s.result[7:0];
        OFS_LOAD_HIGH: d[0] = s.result[8];
        OFS_FLAGS:     d[1:0] = s.flags;
        OFS_MASK:      d[1:0] = s.mask;
        OFS_STATUS: begin
          d[1:0]  = s.st;
          d[2]    = s.clk_valid;
          d[3]    = s.ext_sel;
          d[4]    = s.meas_busy;
          d[11:8] = on;
        end
        OFS_TUNE0:     d[13:0] = s.tune[0];
        OFS_TUNE1:     d[13:0] = s.tune[1];
        default:       d = 32'h0;
      endcase
    end
    return d;
  endfunction

  logic       apb_go;
  logic       apb_wr;
  logic       e_rise;
  logic [9:0] e_sum;
  logic [1:0] set_f;
  logic [1:0] clr_f;

  assign apb_go   = psel && penable && !q.pready;
  assign apb_wr   = psel && penable && q.pready && pwrite;
  assign pin_rise = en_pin && !q.pin_prev;
  assign pin_fall = !en_pin && q.pin_prev;
  assign allowed  = (q.st != ST_OTP_LOAD);
  assign on_bits  = {q.l_on, q.c_on};
  assign pin_bits = {q.l_pin, q.c_pin};
  assign e_rise   = sync_clock_input && !q.clk_prev;
  assign e_sum    = q.edges + {9'h0, e_rise};

  always_comb begin
    n       = q;
    set_f   = 2'b00;
    clr_f   = 2'b00;
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    n.tick    = 1'b0;
    if (apb_go) begin
      n.pready  = 1'b1;
      n.pslverr = (paddr[1:0] != 2'b00) || (paddr > OFS_TUNE1);
      n.prdata  = n.pslverr ? 32'h0 : read_word(q, paddr, reg_on);
    end
    if (q.tick_cnt == 20'h0) begin
      n.tick_cnt = 20'(DELAY_STEP_CYCLES - 1);
      n.tick     = 1'b1;
    end else begin
      n.tick_cnt = q.tick_cnt - 20'h1;
    end
    if (q.meas_busy) begin
      if (q.meas_cnt == 16'h0) begin
        n.meas_busy = 1'b0;
        n.result    = q.sel ? load_sense1 : load_sense0;
        set_f[FLAG_MEAS] = 1'b1;
      end else begin
        n.meas_cnt = q.meas_cnt - 16'h1;
      end
    end
    n.clk_prev = sync_clock_input;
    if (!q.pll_en) begin
      n.win_cnt   = 11'h0;
      n.edges     = 10'h0;
      n.clk_valid = 1'b0;
    end else if (q.win_cnt == 11'(DET_WINDOW_CYC - 1)) begin
      n.win_cnt   = 11'h0;
      n.edges     = 10'h0;
      n.clk_valid = window_ok(e_sum, q.freq);
      if (n.clk_valid != q.clk_valid) begin
        set_f[FLAG_SYNC] = 1'b1;
      end
    end else begin
      n.win_cnt = q.win_cnt + 11'h1;
      n.edges   = e_sum;
    end
    unique case (q.st)
      ST_OTP_LOAD: begin
        n.c_fpwm = otp_fpwm;
        n.dly    = otp_delays;
        n.tune   = {otp_tune1, otp_tune0};
        n.pll_en = otp_pll_en;
        n.st     = ST_STANDBY;
        if (otp_pll_en) begin
          set_f[FLAG_SYNC] = 1'b1;
        end
      end
      ST_STANDBY: begin
        if (|reg_on[1:0]) begin
          n.st = ST_ACTIVE;
          if (q.pll_en && !q.clk_valid) begin
            set_f[FLAG_SYNC] = 1'b1;
          end
        end
      end
      ST_ACTIVE: begin
        if (!(|reg_on[1:0])) begin
          n.st = ST_STANDBY;
        end
      end
    endcase
    if (apb_wr && allowed && paddr[1:0] == 2'b00) begin
      if (paddr[7:4] == OFS_CTRL_BASE[7:4]) begin
        if (paddr[3] == 1'b0) begin
          n.c_on[paddr[2]]   = pwdata[ON_BIT];
          n.c_pin[paddr[2]]  = pwdata[PIN_BIT];
          n.c_fpwm[paddr[2]] = pwdata[FPWM_BIT];
        end else begin
          n.l_on[paddr[2]]  = pwdata[ON_BIT];
          n.l_pin[paddr[2]] = pwdata[PIN_BIT];
        end
      end else if (paddr[7:4] == OFS_DELAY_BASE[7:4]) begin
        n.dly[paddr[3:2]] = pwdata[7:0];
      end else begin
        case (paddr)
          OFS_CONFIG: n.dith = pwdata[0];
          OFS_PLL_CTRL: begin
            n.pll_en = pwdata[PLL_EN_BIT];
            n.freq   = pwdata[FREQ_LSB+4:FREQ_LSB];
          end
          OFS_MEAS_SEL: begin
            n.sel       = pwdata[0];
            n.meas_busy = 1'b1;
            n.meas_cnt  = 16'(MEAS_CYCLES - 1);
          end
          OFS_FLAGS:  clr_f  = pwdata[1:0];
          OFS_MASK:   n.mask = pwdata[1:0];
          OFS_TUNE0:  n.tune[0] = pwdata[13:0];
          OFS_TUNE1:  n.tune[1] = pwdata[13:0];
          default:    n.mask = q.mask;
        endcase
      end
    end
    n.flags = (q.flags & ~clr_f) | set_f;
    n.irq   = |(n.flags & ~n.mask);
    for (int i = 0; i < 2; i++) begin
      n.pwm[i] = q.c_fpwm[i]
               || (q.meas_busy && (q.sel == i[0]))
               || ((i == 0 ? load_sense0 : load_sense1) >= PWM_CODE);
    end
    n.dither_out = q.dith && !q.pll_en;
    n.det_on     = q.pll_en;
    n.ext_sel    = q.pll_en && q.clk_valid;
    n.pin_prev   = en_pin;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_ena
    reg_enable_delay u_ena (
      .mclk       (mclk),
      .sys_rst    (sys_rst),
      .allowed    (allowed),
      .on_bit     (on_bits[g]),
      .pin_follow (pin_bits[g]),
      .pin_level  (en_pin),
      .pin_rise   (pin_rise),
      .pin_fall   (pin_fall),
      .tick       (q.tick),
      .dly_on     (q.dly[g][DLY_ON_LSB+3:DLY_ON_LSB]),
      .dly_off    (q.dly[g][DLY_OFF_LSB+3:DLY_OFF_LSB]),
      .reg_on     (reg_on[g])
    );
  end

  assign prdata             = q.prdata;
  assign pready             = q.pready;
  assign pslverr            = q.pslverr;
  assign conv_on            = reg_on[1:0];
  assign linear_on          = reg_on[3:2];
  assign conv_pwm           = q.pwm;
  assign dither_on          = q.dither_out;
  assign detector_on        = q.det_on;
  assign ext_clock_selected = q.ext_sel;
  assign conv_tuning0       = q.tune[0];
  assign conv_tuning1       = q.tune[1];
  assign int_out            = q.irq;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence meas_start;
    apb_wr && allowed && paddr == OFS_MEAS_SEL;
  endsequence
  sequence meas_end;
    q.meas_busy && q.meas_cnt == 16'h0;
  endsequence

  a_meas_pwm_forced: assert property (
    q.meas_busy && !q.sel |=> conv_pwm[0])
    else $error("measured core not forced to PWM");
  a_meas_bounded: assert property (q.meas_cnt < 16'(MEAS_CYCLES))
    else $error("measurement counter beyond its limit");
  a_meas_start_busy: assert property (
    meas_start |=> q.meas_busy)
    else $error("selection write did not start a measurement");
  a_meas_done_flag: assert property (
    meas_end ##0 !(apb_wr && allowed && paddr == OFS_MEAS_SEL)
    |=> q.flags[FLAG_MEAS] && !q.meas_busy)
    else $error("measurement end did not set its flag");
  a_result_hold: assert property (
    !(q.meas_busy && q.meas_cnt == 16'h0) |=> $stable(q.result))
    else $error("load result changed outside completion");
  a_dither_gate: assert property (q.pll_en |=> !dither_on)
    else $error("dither active while PLL enabled");
  a_no_sync_irq: assert property (
    !q.pll_en && q.st != ST_OTP_LOAD |=> !$rose(q.flags[FLAG_SYNC]))
    else $error("sync flag set with PLL disabled");
  a_irq_masked: assert property (
    (q.flags & ~q.mask) == 2'b00 ##1 (q.flags & ~q.mask) == 2'b00
    |-> !int_out)
    else $error("interrupt raised with every flag masked");
  a_pwm_heavy_load: assert property (
    load_sense0 >= PWM_CODE |=> conv_pwm[0])
    else $error("heavy load did not select PWM");
  a_apb_one_wait: assert property (
    apb_go |=> pready ##1 !pready)
    else $error("APB answer not a single ready cycle");

endmodule

// File: ext_clock_source.sv
/*
  Model of the external clock source that feeds the sync clock input.
  Assumes the bench sets the half period in system clock cycles.
*/
`timescale 1ns/100ps
module ext_clock_source (
  input  wire logic       mclk,
  input  wire logic       run,
  input  wire logic [7:0] half_cyc,
  output logic            sync_clock_input
);
  logic [7:0] cnt_q;

  initial begin
    cnt_q = 8'h00;
    sync_clock_input = 1'b0;
  end

  // Stands low while stopped, otherwise toggles every half period.
  always @(posedge mclk) begin
    if (!run) begin
      cnt_q <= 8'h00;
      sync_clock_input <= 1'b0;
    end else if (cnt_q + 8'h01 >= half_cyc) begin
      cnt_q <= 8'h00;
      sync_clock_input <= ~sync_clock_input;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

// File: tb_top.sv
/*
  Self-checking bench for the regulator enable, clock and load monitor.
  Assumes the design package and the external clock source model.
*/
`timescale 1ns/100ps
module tb_top;
  import pwr_pkg::*;
  localparam int MC = 20;
  logic        mclk = 1'h0;
  logic        sys_rst = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er;
  logic        en_pin = 1'h0;
  logic        otp_pll_en = 1'h0;
  logic        run = 1'h0;
  logic [7:0]  half_cyc = 8'h10;
  logic        sync_clock_input;
  logic [8:0]  load_sense0 = 9'h000;
  logic [8:0]  load_sense1 = 9'h000;
  logic [1:0]  conv_on, linear_on, conv_pwm;
  logic        dither_on, detector_on, ext_clock_selected, int_out;
  logic [13:0] conv_tuning0, conv_tuning1;
  logic [4:0]  obs;
  int          mismatches = 0;
  int          comparisons = 0;
  int          n;

  assign obs = {ext_clock_selected, linear_on, conv_on};

  always #4 mclk = ~mclk;

  ext_clock_source i_src (.mclk(mclk), .run(run), .half_cyc(half_cyc),
    .sync_clock_input(sync_clock_input));

  pwr_ctrl_top #(.MEAS_CYCLES(MC), .DELAY_STEP_CYCLES(8)) i_dut (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .en_pin(en_pin),
    .sync_clock_input(sync_clock_input), .load_sense0(load_sense0),
    .load_sense1(load_sense1), .otp_fpwm(2'h2), .otp_delays(32'h33),
    .otp_tune0(14'h3234), .otp_tune1(14'h0000), .otp_pll_en(otp_pll_en),
    .conv_on(conv_on), .linear_on(linear_on), .conv_pwm(conv_pwm),
    .dither_on(dither_on), .detector_on(detector_on),
    .ext_clock_selected(ext_clock_selected), .conv_tuning0(conv_tuning0),
    .conv_tuning1(conv_tuning1), .int_out(int_out));

  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (k == 20) begin
      mismatches++;
      $display("mismatch at %0t: bus hang", $time);
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] e, input string m);
    apb(1'h0, a, 32'h0);
    chk(rd, e, m);
  endtask

  task settle(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask

  task wait_on(input int i, input logic v);
    n = 0;
    while (obs[i] !== v && n < 4000) begin
      @(posedge mclk);
      n++;
    end
    if (n == 4000) begin
      mismatches++;
      $display("mismatch at %0t: wait timeout", $time);
      wrap_up();
    end
  endtask

  task t_reset;
    settle(4);
    rdchk(OFS_STATUS, 32'h1, "standby state");
    rdchk(OFS_CTRL_BASE + 8'h04, 32'h4, "otp forced pwm");
    rdchk(OFS_DELAY_BASE, 32'h33, "otp delays");
    chk(32'(conv_pwm), 32'h2, "pwm from otp");
    chk(32'(conv_tuning0), 32'h3234, "otp tuning");
    apb(1'h1, OFS_CTRL_BASE + 8'h04, 32'h0);
    apb(1'h1, OFS_TUNE1, 32'h1ABC);
    settle(2);
    chk(32'(conv_pwm), 32'h0, "otp overwrite");
    chk(32'(conv_tuning1), 32'h1ABC, "tuning overwrite");
    apb(1'h0, 8'h48, 32'h0);
    chk(32'(er), 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped read");
    $display("test reset done");
  endtask

  task t_pwm;
    logic [8:0] lv [3];
    logic       ev [3];
    lv = '{PWM_CODE - 9'h001, PWM_CODE, 9'h1FF};
    ev = '{1'h0, 1'h1, 1'h1};
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      load_sense0 <= lv[i];
      settle(3);
      chk(32'(conv_pwm[0]), 32'(ev[i]), "auto mode");
    end
    @(posedge mclk);
    load_sense0 <= 9'h000;
    apb(1'h1, OFS_CTRL_BASE, 32'h4);
    settle(3);
    chk(32'(conv_pwm[0]), 32'h1, "forced pwm");
    apb(1'h1, OFS_CTRL_BASE, 32'h0);
    apb(1'h1, OFS_CONFIG, 32'h1);
    settle(2);
    chk(32'({dither_on, detector_on}), 32'h2, "dither on rc");
    $display("test pwm done");
  endtask

  task t_enable;
    apb(1'h1, OFS_CTRL_BASE, 32'h1);
    settle(2);
    chk(32'(conv_on), 32'h1, "register on");
    apb(1'h0, OFS_STATUS, 32'h0);
    chk(32'(rd[1:0]), 32'h2, "active state");
    apb(1'h1, OFS_CTRL_BASE, 32'h3);
    settle(2);
    chk(32'(conv_on), 32'h0, "pin low");
    @(posedge mclk);
    en_pin <= 1'h1;
    wait_on(0, 1'h1);
    chk(32'(n >= 14 && n <= 30), 32'h1, "turn on delay");
    @(posedge mclk);
    en_pin <= 1'h0;
    wait_on(0, 1'h0);
    chk(32'(n >= 14 && n <= 30), 32'h1, "turn off delay");
    apb(1'h1, OFS_CTRL_BASE + 8'h08, 32'h3);
    @(posedge mclk);
    en_pin <= 1'h1;
    wait_on(2, 1'h1);
    chk(32'(n <= 4), 32'h1, "zero delay");
    wait_on(0, 1'h1);
    apb(1'h1, OFS_CTRL_BASE, 32'h2);
    apb(1'h1, OFS_CTRL_BASE + 8'h08, 32'h2);
    settle(2);
    chk(32'(obs[3:0]), 32'h0, "bit clear wins");
    @(posedge mclk);
    en_pin <= 1'h0;
    $display("test enable done");
  endtask

  task t_meas;
    @(posedge mclk);
    load_sense1 <= 9'h005;
    apb(1'h1, OFS_MEAS_SEL, 32'h1);
    settle(2);
    chk(32'(conv_pwm[1]), 32'h1, "pwm in measure");
    @(posedge mclk);
    load_sense1 <= 9'h1F5;
    settle(MC);
    chk(32'(int_out), 32'h1, "measure irq");
    rdchk(OFS_FLAGS, 32'h1, "measure flag");
    rdchk(OFS_LOAD_LOW, 32'hF5, "result low");
    rdchk(OFS_LOAD_HIGH, 32'h1, "result high");
    load_sense0 <= 9'h02A;
    apb(1'h1, OFS_MEAS_SEL, 32'h0);
    rdchk(OFS_LOAD_LOW, 32'hF5, "hold low");
    rdchk(OFS_LOAD_HIGH, 32'h1, "hold high");
    settle(MC);
    rdchk(OFS_LOAD_LOW, 32'h2A, "core0 low");
    rdchk(OFS_LOAD_HIGH, 32'h0, "core0 high");
    apb(1'h1, OFS_MASK, 32'h1);
    settle(2);
    chk(32'(int_out), 32'h0, "measure mask");
    apb(1'h1, OFS_FLAGS, 32'h1);
    apb(1'h1, OFS_MASK, 32'h0);
    rdchk(OFS_FLAGS, 32'h0, "flag clear");
    $display("test measure done");
  endtask

  task t_clock;
    logic [7:0] h [4];
    logic       e [4];
    h = '{8'h10, 8'h0C, 8'h10, 8'h19};
    e = '{1'h1, 1'h0, 1'h1, 1'h0};
    apb(1'h1, OFS_PLL_CTRL, 32'h301);
    settle(2);
    chk(32'({dither_on, detector_on}), 32'h1, "pll on");
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      half_cyc <= h[i];
      run <= 1'h1;
      wait_on(4, e[i]);
      chk(32'(n < 4000), 32'h1, "detector range");
    end
    rdchk(OFS_FLAGS, 32'h2, "sync flag");
    apb(1'h1, OFS_PLL_CTRL, 32'h1701);
    half_cyc <= 8'h03;
    wait_on(4, 1'h1);
    chk(32'(n < 4000), 32'h1, "top code");
    run <= 1'h0;
    wait_on(4, 1'h0);
    chk(32'(n < 4000), 32'h1, "clock lost");
    apb(1'h1, OFS_FLAGS, 32'h3);
    apb(1'h1, OFS_MASK, 32'h3);
    apb(1'h1, OFS_CTRL_BASE + 8'h04, 32'h1);
    settle(2);
    rdchk(OFS_FLAGS, 32'h2, "missing at enable");
    chk(32'(int_out), 32'h0, "sync mask");
    apb(1'h1, OFS_MASK, 32'h1);
    settle(2);
    chk(32'(int_out), 32'h1, "sync unmasked");
    apb(1'h1, OFS_PLL_CTRL, 32'h0);
    apb(1'h1, OFS_FLAGS, 32'h3);
    half_cyc <= 8'h10;
    run <= 1'h1;
    settle(3000);
    chk(32'({detector_on, ext_clock_selected}), 32'h0, "rc only");
    rdchk(OFS_FLAGS, 32'h0, "no sync flag");
    $display("test clock done");
  endtask

  task t_otp_pll;
    @(posedge mclk);
    sys_rst <= 1'h1;
    otp_pll_en <= 1'h1;
    settle(2);
    chk(32'({obs, int_out}), 32'h0, "outputs in second reset");
    @(posedge mclk);
    sys_rst <= 1'h0;
    settle(4);
    chk(32'(detector_on), 32'h1, "otp detector on");
    rdchk(OFS_PLL_CTRL, 32'h1, "otp pll enable");
    rdchk(OFS_FLAGS, 32'h2, "missing clock at standby");
    chk(32'(int_out), 32'h1, "missing clock irq");
    $display("test otp pll done");
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    #1;
    chk(32'({obs[3:0], int_out}), 32'h0, "outputs in reset");
    @(posedge mclk);
    sys_rst <= 1'h0;
    t_reset();
    t_pwm();
    t_enable();
    t_meas();
    t_clock();
    t_otp_pll();
    wrap_up();
  end
endmodule
